/* File: logic/tsc_timer_map.vh */
`ifndef TSC_TIMER_MAP_VH
`define TSC_TIMER_MAP_VH
// ==========================================
// register indices (byte address = 4 * index)
`define TSC_IDX_CAP1_HI 6'h20
`define TSC_IDX_CAP1_LO 6'h21
`define TSC_IDX_CMP1_HI 6'h22
`define TSC_IDX_CMP1_LO 6'h23
`define TSC_IDX_CAP2_HI 6'h24
`define TSC_IDX_CAP2_LO 6'h25
`define TSC_IDX_CMP2_HI 6'h26
`define TSC_IDX_CMP2_LO 6'h27
`define TSC_IDX_CNT_HI 6'h28
`define TSC_IDX_CNT_LO 6'h29
`define TSC_IDX_ALT_HI 6'h2a
`define TSC_IDX_ALT_LO 6'h2b
`define TSC_IDX_CTRL1 6'h2c
`define TSC_IDX_CTRL2 6'h2d
`define TSC_IDX_FLAGS 6'h2e
// ==========================================
// first control register fields
`define TSC_C1_CAP1_IE 7
`define TSC_C1_CAP2_IE 6
`define TSC_C1_CMP1_IE 5
`define TSC_C1_OVF_IE 4
`define TSC_C1_CMP1_PIN 3
`define TSC_C1_EDGE1 2
`define TSC_C1_EDGE2 1
`define TSC_C1_CMP1_LVL 0
`define TSC_C1_RESET 8'h00
// ==========================================
// second control register fields
`define TSC_C2_CMP2_IE 5
`define TSC_C2_CMP2_PIN 3
`define TSC_C2_CMP2_LVL 0
`define TSC_C2_MASK 8'h29
`define TSC_C2_RESET 8'h00
// ==========================================
// flag vector positions inside the block
`define TSC_F_CAP1 4
`define TSC_F_CAP2 3
`define TSC_F_CMP1 2
`define TSC_F_OVF 1
`define TSC_F_CMP2 0
// ==========================================
// counter and prescaler
`define TSC_CNT_RESET 16'hfffc
`define TSC_CNT_WRAP 16'hffff
`define TSC_PRESCALE 4
`endif

/* File: logic/tsc_timer_capture.v */
// Function
// - control2 bit5 gates compare-two interrupt
// - control2 bit3 enables compare-two pin, reset clears
// - control2 bit0 is level loaded on match
// - control2 bits 1,2,4,6,7 read zero
// - flag clear needs status then data access
// - capture-one flag bit7, cleared via low read
// - capture-two flag bit6, cleared via low read
// - compare-one flag bit5, cleared via low access
// - overflow flag bit4, cleared via counter low
// - compare-two flag bit1, cleared via low access
// - status bits 3,2 show capture pin levels
// - capture-one latches counter at 0x20/0x21
// - capture-two latches counter at 0x24/0x25
// - captured value is prior count plus one
// - capture resolution four bus clocks
// - every valid edge overwrites capture register unless a high read has locked it
// - high read blocks capture until low read
// - reset leaves capture contents unchanged
// - compare bytes plain read/write, never altered
// - counter advances once per four clocks
// - edge select: set rising, clear falling
// - compare-two checked per tick, drives pin
`timescale 1ns/1ps
`include "tsc_timer_map.vh"

module tsc_timer_capture #(
  parameter CNT_W = 16
) (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire capture_input_one_in,
  input wire capture_input_two_in,
  output wire compare_output_one_out,
  output wire compare_output_one_oe_out,
  output wire compare_output_two_out,
  output wire compare_output_two_oe_out,
  output wire timer_irq_out
);

  // ==========================================
  // bus handshake
  reg ack_reg;
  wire req = avs_read_in | avs_write_in;
  wire take = req & ~ack_reg;
  wire rd = take & avs_read_in;
  wire wr = take & avs_write_in & avs_byteenable_in[0];
  wire acc = take;
  wire [5:0] idx = avs_address_in[7:2];
  wire [7:0] wdata = avs_writedata_in[7:0];

  // one wait state: request taken on first edge, answered on second
  assign avs_waitrequest_out = req & ~ack_reg;

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
    end
  end

  // ==========================================
  // prescaler and free-running counter
  reg [1:0] pre_reg;
  reg [CNT_W-1:0] cnt_reg;
  // last prescaler count, kept at full integer width so the compare pads on purpose
  localparam integer PRE_LAST = `TSC_PRESCALE - 1;
  // one counter step is four bus clocks
  wire tick = ({30'h0, pre_reg} == PRE_LAST);

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_reg <= 2'h0;
      cnt_reg <= `TSC_CNT_RESET;
    end else begin
      pre_reg <= pre_reg + 2'h1;
      if (tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  wire ovf_evt = tick & (cnt_reg == `TSC_CNT_WRAP);

  // ==========================================
  // control registers
  reg [7:0] ctrl1_reg;
  reg [7:0] ctrl2_reg;

  // reset clears pin enable along with the rest
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl1_reg <= `TSC_C1_RESET;
      ctrl2_reg <= `TSC_C2_RESET;
    end else if (wr) begin
      if (idx == `TSC_IDX_CTRL1) begin
        ctrl1_reg <= wdata;
      end
      if (idx == `TSC_IDX_CTRL2) begin
        ctrl2_reg <= wdata & `TSC_C2_MASK;
      end
    end
  end

  // ==========================================
  // compare registers, no reset on purpose
  reg [CNT_W-1:0] cmp1_reg;
  reg [CNT_W-1:0] cmp2_reg;

  always @(posedge ref_clk_in) begin
    if (wr) begin
      if (idx == `TSC_IDX_CMP1_HI) cmp1_reg[15:8] <= wdata;
      if (idx == `TSC_IDX_CMP1_LO) cmp1_reg[7:0] <= wdata;
      if (idx == `TSC_IDX_CMP2_HI) cmp2_reg[15:8] <= wdata;
      if (idx == `TSC_IDX_CMP2_LO) cmp2_reg[7:0] <= wdata;
    end
  end

  // high-byte write inhibits compare until the low byte follows
  reg cmp1_hold_reg;
  reg cmp2_hold_reg;
  reg lvl1_reg;
  reg lvl2_reg;
  wire cmp1_evt = tick & ~cmp1_hold_reg & (cmp1_reg == cnt_reg);
  // compare two evaluated on each tick
  wire cmp2_evt = tick & ~cmp2_hold_reg & (cmp2_reg == cnt_reg);

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp1_hold_reg <= 1'b0;
      cmp2_hold_reg <= 1'b0;
      lvl1_reg <= 1'b0;
      lvl2_reg <= 1'b0;
    end else begin
      if (wr && idx == `TSC_IDX_CMP1_HI) cmp1_hold_reg <= 1'b1;
      else if (wr && idx == `TSC_IDX_CMP1_LO) cmp1_hold_reg <= 1'b0;
      if (wr && idx == `TSC_IDX_CMP2_HI) cmp2_hold_reg <= 1'b1;
      else if (wr && idx == `TSC_IDX_CMP2_LO) cmp2_hold_reg <= 1'b0;
      if (cmp1_evt) lvl1_reg <= ctrl1_reg[`TSC_C1_CMP1_LVL];
      // level bit copied to output level on match
      if (cmp2_evt) lvl2_reg <= ctrl2_reg[`TSC_C2_CMP2_LVL];
    end
  end

  assign compare_output_two_oe_out = ctrl2_reg[`TSC_C2_CMP2_PIN];
  assign compare_output_two_out = lvl2_reg;
  assign compare_output_one_oe_out = ctrl1_reg[`TSC_C1_CMP1_PIN];
  assign compare_output_one_out = lvl1_reg;

  // ==========================================
  // capture edge detection
  reg in1_prev_reg;
  reg in2_prev_reg;
  wire edge1_sel = ctrl1_reg[`TSC_C1_EDGE1];
  wire edge2_sel = ctrl1_reg[`TSC_C1_EDGE2];
  wire cap1_edge = edge1_sel ? (capture_input_one_in & ~in1_prev_reg) : (~capture_input_one_in & in1_prev_reg);
  wire cap2_edge = edge2_sel ? (capture_input_two_in & ~in2_prev_reg) : (~capture_input_two_in & in2_prev_reg);

  // previous levels start high, matching pulled-up pins
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in1_prev_reg <= 1'b1;
      in2_prev_reg <= 1'b1;
    end else begin
      in1_prev_reg <= capture_input_one_in;
      in2_prev_reg <= capture_input_two_in;
    end
  end

  // ==========================================
  // capture registers and their read lock
  reg [CNT_W-1:0] cap1_reg;
  reg [CNT_W-1:0] cap2_reg;
  reg cap1_lock_reg;
  reg cap2_lock_reg;
  // one more than the count before the edge
  wire [CNT_W-1:0] cap_value = cnt_reg + 16'h0001;

  // high read locks, low read unlocks
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap1_lock_reg <= 1'b0;
      cap2_lock_reg <= 1'b0;
    end else begin
      if (rd && idx == `TSC_IDX_CAP1_HI) cap1_lock_reg <= 1'b1;
      else if (rd && idx == `TSC_IDX_CAP1_LO) cap1_lock_reg <= 1'b0;
      if (rd && idx == `TSC_IDX_CAP2_HI) cap2_lock_reg <= 1'b1;
      else if (rd && idx == `TSC_IDX_CAP2_LO) cap2_lock_reg <= 1'b0;
    end
  end

  // no reset term, contents survive reset
  always @(posedge ref_clk_in) begin
    if (cap1_edge && !cap1_lock_reg) begin
      cap1_reg <= cap_value;
    end
    if (cap2_edge && !cap2_lock_reg) begin
      cap2_reg <= cap_value;
    end
  end

  // ==========================================
  // counter read buffer keeps high/low pairs coherent
  reg [7:0] cbuf_reg;
  reg cbuf_valid_reg;
  wire cnt_hi_rd = rd & ((idx == `TSC_IDX_CNT_HI) | (idx == `TSC_IDX_ALT_HI));
  wire cnt_lo_rd = rd & ((idx == `TSC_IDX_CNT_LO) | (idx == `TSC_IDX_ALT_LO));
  wire [7:0] cnt_lo_view = cbuf_valid_reg ? cbuf_reg : cnt_reg[7:0];

  // only the first high read freezes the low byte
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cbuf_reg <= 8'h00;
      cbuf_valid_reg <= 1'b0;
    end else if (cnt_hi_rd && !cbuf_valid_reg) begin
      cbuf_reg <= cnt_reg[7:0];
      cbuf_valid_reg <= 1'b1;
    end else if (cnt_lo_rd) begin
      cbuf_valid_reg <= 1'b0;
    end
  end

  // ==========================================
  // status flags with two-step clearing
  reg [4:0] flags_reg;
  reg [4:0] armed_reg;
  wire [4:0] set_evt;
  wire [4:0] clr_evt;
  wire [4:0] clr_ok;
  wire [4:0] flags_next;
  wire flags_acc = acc & (idx == `TSC_IDX_FLAGS);

  // capture one edge sets, low byte read clears
  assign set_evt[`TSC_F_CAP1] = cap1_edge & ~cap1_lock_reg;
  assign clr_evt[`TSC_F_CAP1] = rd & (idx == `TSC_IDX_CAP1_LO);
  // capture two edge sets, low byte read clears
  assign set_evt[`TSC_F_CAP2] = cap2_edge & ~cap2_lock_reg;
  assign clr_evt[`TSC_F_CAP2] = rd & (idx == `TSC_IDX_CAP2_LO);
  // compare one match sets, low access clears
  assign set_evt[`TSC_F_CMP1] = cmp1_evt;
  assign clr_evt[`TSC_F_CMP1] = acc & (idx == `TSC_IDX_CMP1_LO);
  // wrap sets, counter low read clears
  assign set_evt[`TSC_F_OVF] = ovf_evt;
  assign clr_evt[`TSC_F_OVF] = rd & (idx == `TSC_IDX_CNT_LO);
  // compare two match sets, low access clears
  assign set_evt[`TSC_F_CMP2] = cmp2_evt;
  assign clr_evt[`TSC_F_CMP2] = acc & (idx == `TSC_IDX_CMP2_LO);

  // only a flag armed by the status access may clear
  assign clr_ok = clr_evt & armed_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
      // set wins over a clear in the same cycle
      assign flags_next[gi] = set_evt[gi] | (flags_reg[gi] & ~clr_ok[gi]);
    end
  endgenerate

  // status access arms, data access consumes
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= 5'h00;
      armed_reg <= 5'h00;
    end else begin
      flags_reg <= flags_next;
      if (flags_acc) begin
        armed_reg <= flags_reg;
      end else begin
        armed_reg <= armed_reg & ~clr_evt;
      end
    end
  end

  // each flag requests only when its enable is set
  assign timer_irq_out = (flags_reg[`TSC_F_CAP1] & ctrl1_reg[`TSC_C1_CAP1_IE])
                       | (flags_reg[`TSC_F_CAP2] & ctrl1_reg[`TSC_C1_CAP2_IE])
                       | (flags_reg[`TSC_F_CMP1] & ctrl1_reg[`TSC_C1_CMP1_IE])
                       | (flags_reg[`TSC_F_OVF] & ctrl1_reg[`TSC_C1_OVF_IE])
                       | (flags_reg[`TSC_F_CMP2] & ctrl2_reg[`TSC_C2_CMP2_IE]);

  // ==========================================
  // read mux; unmapped addresses read zero
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `TSC_IDX_CAP1_HI: rd_byte = cap1_reg[15:8];
      `TSC_IDX_CAP1_LO: rd_byte = cap1_reg[7:0];
      `TSC_IDX_CMP1_HI: rd_byte = cmp1_reg[15:8];
      `TSC_IDX_CMP1_LO: rd_byte = cmp1_reg[7:0];
      `TSC_IDX_CAP2_HI: rd_byte = cap2_reg[15:8];
      `TSC_IDX_CAP2_LO: rd_byte = cap2_reg[7:0];
      `TSC_IDX_CMP2_HI: rd_byte = cmp2_reg[15:8];
      `TSC_IDX_CMP2_LO: rd_byte = cmp2_reg[7:0];
      `TSC_IDX_CNT_HI: rd_byte = cnt_reg[15:8];
      `TSC_IDX_CNT_LO: rd_byte = cnt_lo_view;
      `TSC_IDX_ALT_HI: rd_byte = cnt_reg[15:8];
      `TSC_IDX_ALT_LO: rd_byte = cnt_lo_view;
      `TSC_IDX_CTRL1: rd_byte = ctrl1_reg;
      // mask keeps unused bits at zero
      `TSC_IDX_CTRL2: rd_byte = ctrl2_reg & `TSC_C2_MASK;
      // live pin levels in bits 3 and 2
      `TSC_IDX_FLAGS: rd_byte = {flags_reg[`TSC_F_CAP1], flags_reg[`TSC_F_CAP2],
                                 flags_reg[`TSC_F_CMP1], flags_reg[`TSC_F_OVF],
                                 capture_input_one_in, capture_input_two_in,
                                 flags_reg[`TSC_F_CMP2], 1'b0};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data registered at the taking edge, stands through the answer
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (rd) begin
      avs_readdata_out <= {24'h000000, rd_byte};
    end
  end

endmodule

/* File: tb/tsc_timer_capture_properties.sv */
`timescale 1ns/1ps
module tsc_timer_capture_props (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire capture_input_one_in,
  input wire capture_input_two_in,
  input wire compare_output_two_out,
  input wire compare_output_two_oe_out,
  input wire timer_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================
  // bus phases
  sequence s_req;
    $rose(avs_read_in | avs_write_in);
  endsequence
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  sequence s_rd(idx);
    avs_read_in && !avs_waitrequest_out && avs_address_in[7:2] == idx;
  endsequence
  sequence s_wr_ctrl2;
    avs_write_in && !avs_waitrequest_out && avs_address_in[7:2] == 6'h2d && avs_byteenable_in[0];
  endsequence
  // ==========================================
  // checks
  AST_ONE_WAIT: assert property (s_req |-> s_one_wait)
    else $error("request not answered after one wait state");
  AST_RD_STANDS: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  AST_C2_ZERO: assert property (s_rd(6'h2d) |-> (avs_readdata_out & 32'hffff_ffd6) == 32'h0)
    else $error("unused control bits not zero");
  AST_C2_OE: assert property (s_wr_ctrl2 |=> compare_output_two_oe_out == $past(avs_writedata_in[3]))
    else $error("pin enable does not follow control write");
  AST_RST_OUT: assert property ($rose(reset_n_in) |-> !compare_output_two_oe_out && !timer_irq_out)
    else $error("outputs active right after reset");
  AST_PIN_LVL: assert property (s_rd(6'h2e) ##0 $stable({capture_input_one_in, capture_input_two_in})
    |-> avs_readdata_out[3:2] == {capture_input_one_in, capture_input_two_in} && !avs_readdata_out[0])
    else $error("status pin bits wrong");
  AST_LVL_TICK: assert property ($changed(compare_output_two_out) |=> $stable(compare_output_two_out)[*3])
    else $error("compare level moved off the counter step");
  AST_RD_UPPER: assert property (s_rd(avs_address_in[7:2]) |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule

bind tsc_timer_capture tsc_timer_capture_props tsc_timer_capture_props_i (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .capture_input_one_in(capture_input_one_in),
  .capture_input_two_in(capture_input_two_in), .compare_output_two_out(compare_output_two_out),
  .compare_output_two_oe_out(compare_output_two_oe_out), .timer_irq_out(timer_irq_out)
);

/* File: tb/tsc_timer_capture_tb.sv */
`timescale 1ns/1ps
module tsc_timer_capture_tb;
  logic ref_clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'h0;
  logic avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic pin_one = 1'h1;
  logic pin_two = 1'h1;
  wire [31:0] rdata;
  wire wreq, out_two, oe_two, irq;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] d, k;
  logic [15:0] v1, v2;
  logic [15:0] tgt;
  logic [5:0] cmp_idx [0:3] = '{6'h22, 6'h23, 6'h26, 6'h27};

  tsc_timer_capture #(.CNT_W(16)) tsc_timer_capture_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .capture_input_one_in(pin_one), .capture_input_two_in(pin_two), .compare_output_one_out(),
    .compare_output_one_oe_out(), .compare_output_two_out(out_two),
    .compare_output_two_oe_out(oe_two), .timer_irq_out(irq)
  );

  // ==========================================
  // clock and hang guard
  initial forever #12.5 ref_clk_in = ~ref_clk_in;
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end

  // ==========================================
  // bus tasks
  task final_report;
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // held until waitrequest is seen low, then released
  task bus(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] rd);
    avs_address_in <= {a, 2'h0};
    avs_writedata_in <= {24'h0, wd};
    avs_read_in <= !w;
    avs_write_in <= w;
    @(posedge ref_clk_in);
    while (wreq !== 1'h0) @(posedge ref_clk_in);
    rd = rdata[7:0];
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
    @(posedge ref_clk_in);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] wd);
    bus(1'h1, a, wd, d);
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task rc(input string n, input logic [5:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00, d);
    chk(n, {8'h0, e}, {8'h0, d});
  endtask
  // high byte first, so the pair is coherent
  task rd16(input logic [5:0] a, output logic [15:0] v);
    bus(1'h0, a, 8'h00, v[15:8]);
    bus(1'h0, a + 6'h01, 8'h00, v[7:0]);
  endtask

  // ==========================================
  // main sequence
  initial begin
    tick(8);
    reset_n_in <= 1'h1;
    tick(1);
    // compare bytes first: they power up unknown
    for (int i = 0; i < 4; i++) wr(cmp_idx[i], 8'h5a ^ 8'(i));
    rc("ctrl2 reset", 6'h2d, 8'h00);
    wr(6'h2d, 8'hff);
    rc("ctrl2 bits", 6'h2d, 8'h29);
    rc("unmapped", 6'h10, 8'h00);
    // capture one rising, capture two falling
    wr(6'h2c, 8'h04);
    pin_one <= 1'h0;
    tick(4);
    bus(1'h0, 6'h2b, 8'h00, k);
    pin_one <= 1'h1;
    pin_two <= 1'h0;
    tick(8);
    pin_one <= 1'h0;
    tick(8);
    pin_one <= 1'h1;
    tick(4);
    rd16(6'h24, v2);
    rd16(6'h20, v1);
    d = v2[7:0] - k - 8'h01;
    chk("capture lag", 16'h0, {8'h0, d & 8'hfe});
    chk("capture step", v2 + 16'h0004, v1);
    // a high read holds off the next capture
    bus(1'h0, 6'h20, 8'h00, k);
    pin_one <= 1'h0;
    pin_two <= 1'h1;
    tick(4);
    pin_one <= 1'h1;
    tick(4);
    bus(1'h0, 6'h21, 8'h00, d);
    chk("capture held", v1, {k, d});
    pin_one <= 1'h0;
    tick(4);
    pin_one <= 1'h1;
    pin_two <= 1'h0;
    tick(4);
    rd16(6'h20, v1);
    rd16(6'h24, v2);
    chk("capture after low", v2, v1);
    // two-step flag clearing
    rc("status", 6'h2e, 8'hd8);
    bus(1'h0, 6'h21, 8'h00, k);
    rc("status", 6'h2e, 8'h58);
    bus(1'h0, 6'h2b, 8'h00, k);
    rc("status", 6'h2e, 8'h58);
    bus(1'h0, 6'h29, 8'h00, k);
    bus(1'h0, 6'h25, 8'h00, k);
    rc("status", 6'h2e, 8'h08);
    // compare two fires forty steps ahead
    rd16(6'h28, v1);
    tgt = v1 + 16'd40;
    wr(6'h26, tgt[15:8]);
    wr(6'h27, tgt[7:0]);
    tick(200);
    chk("level two", 16'h1, {15'h0, out_two});
    chk("pin enable", 16'h1, {15'h0, oe_two});
    chk("irq on", 16'h1, {15'h0, irq});
    wr(6'h2d, 8'h09);
    chk("irq masked", 16'h0, {15'h0, irq});
    wr(6'h27, tgt[7:0]);
    rc("status", 6'h2e, 8'h0a);
    wr(6'h27, tgt[7:0]);
    rc("status", 6'h2e, 8'h08);
    // second reset keeps capture and compare contents
    wr(6'h20, ~v2[15:8]);
    reset_n_in <= 1'h0;
    tick(8);
    reset_n_in <= 1'h1;
    tick(1);
    rd16(6'h20, v1);
    chk("capture kept", v2, v1);
    for (int i = 0; i < 2; i++) rc("compare byte", cmp_idx[i], 8'h5a ^ 8'(i));
    rc("compare two high", 6'h26, tgt[15:8]);
    rc("compare two low", 6'h27, tgt[7:0]);
    rc("ctrl2 reset", 6'h2d, 8'h00);
    final_report();
  end
endmodule
